// ==== src/fbe_consts.vh ====
// Constants of the nonvolatile-memory bit-error response block.
`ifndef FBE_CONSTS_VH
`define FBE_CONSTS_VH
`define FBE_ADDR_CONFIG      4'h0
`define FBE_ADDR_FLAG        4'h1
`define FBE_ADDR_RST_CAUSE   4'h2
`define FBE_ADDR_NMI_VEC     4'h3
`define FBE_ADDR_IRQ_STAT    4'h4
`define FBE_ADDR_IRQ_MASK    4'h5
`define FBE_ADDR_CLK_STAT    4'h6
`define FBE_CFG_RST_EN       0
`define FBE_CFG_UNC_IE       1
`define FBE_CFG_COR_IE       2
`define FBE_FLG_UNC          0
`define FBE_FLG_COR          1
`define FBE_CFG_RESET        16'h0000
`define FBE_CAUSE_NONE       16'h0000
`define FBE_CAUSE_UNC        16'h001C
`define FBE_NMI_UNC          16'h0010
`define FBE_NMI_COR          16'h000E
`define FBE_FAST_LIMIT_KHZ   32'd12000
`define FBE_OSC_FAST_KHZ     32'd16000
`define FBE_RST_PULSE_NS     32'd8
`define FBE_CLK_PERIOD_NS    32'd4
`define FBE_RST_PULSE_CYC    4'h2
`endif

// ==== src/fbe_reset_pulse.v ====
// Stretches a reset request into a power-up-clear pulse of fixed length.
`timescale 1ns/1ps
module fbe_reset_pulse #(
   parameter WIDTH = 4,
   parameter [3:0] CYCLES = 4'h2
) (
   input  wire       clock,
   input  wire       rst,
   input  wire       trigger,
   output wire       pulse
);
   reg [WIDTH-1:0] count_reg;
   always @(posedge clock) begin
      if (rst) begin
         count_reg <= {WIDTH{1'b0}};
      end else if (trigger) begin
         count_reg <= CYCLES[WIDTH-1:0];
      end else if (count_reg != {WIDTH{1'b0}}) begin
         count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign pulse = (count_reg != {WIDTH{1'b0}});
endmodule // fbe_reset_pulse

// ==== src/fbe_bit_error.v ====
// Bit-error detection and response logic of the nonvolatile-memory controller.
// How it works
// - An uncorrectable error during a memory read with memExec high and reset enable set requests a power-up-clear reset.
// - Every uncorrectable error except a false fast-clock detection sets the uncorrectable flag and interrupt status bit 0, which drives irq when mask bit 0 is set.
// - A reset from an uncorrectable error loads its cause code into the reset-cause vector.
// - With the uncorrectable interrupt and reset enables both set, an uncorrectable error other than a false fast-clock detection raises an NMI with its code.
// - With the correctable interrupt enable set, a correctable error raises an NMI with its code, unless an uncorrectable NMI is raised in the same cycle.
// - A fast main clock (internal osc at 16 MHz, or external above 12 MHz) can flag false errors.
// - A false-detection reset leaves the cause vector at zero and the flag clear.
// - With reset enable clear, no NMI comes from an uncorrectable error even with its enable set.
// - After wake from low-power modes 1 to 4 the checker may report errors on intact memory.
`timescale 1ns/1ps
`include "fbe_consts.vh"
module fbe_bit_error #(
   parameter [31:0] FAST_LIMIT_KHZ = `FBE_FAST_LIMIT_KHZ
) (
   input  wire        clock,
   input  wire        rst,
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [15:0] regRdData,
   input  wire        memRead,
   input  wire        memExec,
   input  wire        corrErr,
   input  wire        uncorrErr,
   input  wire        clkFromInternalOsc,
   input  wire [31:0] mainClockKhz,
   input  wire        wakeFromLowPower,
   input  wire        nmiAck,
   output wire        powerUpClearReset,
   output wire        nmiRequest,
   output wire        irq
);
   ////////////////////////////////////////////////////////////////////////
   reg  [2:0]  configReg;
   reg         uncorrFlagReg;
   reg         corrFlagReg;
   reg  [15:0] resetCauseReg;
   reg  [15:0] nmiVecReg;
   reg         nmiPendReg;
   reg         wakeWindowReg;
   reg  [2:0]  irqStatReg;
   reg  [2:0]  irqMaskReg;
   reg  [15:0] rdNext;

   wire uncorrResetEn = configReg[`FBE_CFG_RST_EN];
   wire uncorrIntEn   = configReg[`FBE_CFG_UNC_IE];
   wire corrIntEn     = configReg[`FBE_CFG_COR_IE];

   function addrHit;
      input [3:0] a;
      input [3:0] b;
      begin
         addrHit = (a == b);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // The fast-clock window is where the checker can mis-fire; it is
   // reported but not masked, because the real part shows it too.
   wire fastClock = (clkFromInternalOsc &&
                     mainClockKhz >= `FBE_OSC_FAST_KHZ) ||
                    (!clkFromInternalOsc &&
                     mainClockKhz > FAST_LIMIT_KHZ);
   wire realUncorr = memRead & uncorrErr;
   wire realCorr   = memRead & corrErr;
   // A false uncorrectable hit in the fast window with reset enable set resets the part without
   // leaving any trace in the flag or the cause vector.
   wire falseUncorr = realUncorr & fastClock & memExec;
   wire trueUncorr  = realUncorr & ~falseUncorr;
   wire unResetReq  = realUncorr & memExec & uncorrResetEn;
   // No uncorrectable NMI path exists without the reset enable.
   wire unNmiReq    = trueUncorr & uncorrIntEn & uncorrResetEn;
   wire coNmiReq    = realCorr & corrIntEn;

   wire wrCfg  = regWrite & addrHit(regAddr, `FBE_ADDR_CONFIG);
   wire wrFlg  = regWrite & addrHit(regAddr, `FBE_ADDR_FLAG);
   wire wrStat = regWrite & addrHit(regAddr, `FBE_ADDR_IRQ_STAT);
   wire wrMask = regWrite & addrHit(regAddr, `FBE_ADDR_IRQ_MASK);
   wire rdCause = regRead & addrHit(regAddr, `FBE_ADDR_RST_CAUSE);
   wire rdNmi   = regRead & addrHit(regAddr, `FBE_ADDR_NMI_VEC);

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (rst) begin
         configReg     <= 3'b000;
         uncorrFlagReg <= 1'b0;
         corrFlagReg   <= 1'b0;
         nmiVecReg     <= `FBE_CAUSE_NONE;
         nmiPendReg    <= 1'b0;
         wakeWindowReg <= 1'b0;
         irqStatReg    <= 3'b000;
         irqMaskReg    <= 3'b000;
      end else begin
         if (wrCfg)
            configReg <= regWrData[2:0];
         if (wrMask)
            irqMaskReg <= regWrData[2:0];
         // Set wins over a write-one-to-clear in the same cycle.
         uncorrFlagReg <= trueUncorr |
                          (uncorrFlagReg &
                           ~(wrFlg & regWrData[`FBE_FLG_UNC]));
         corrFlagReg <= realCorr |
                        (corrFlagReg &
                         ~(wrFlg & regWrData[`FBE_FLG_COR]));
         irqStatReg <= {wakeWindowReg & (realCorr | realUncorr),
                        realCorr, trueUncorr} |
                       (irqStatReg & ~({3{wrStat}} & regWrData[2:0]));
         // Errors right after wake may be spurious; the first read ends it.
         if (wakeFromLowPower)
            wakeWindowReg <= 1'b1;
         else if (memRead)
            wakeWindowReg <= 1'b0;
         if (unNmiReq) begin
            nmiVecReg  <= `FBE_NMI_UNC;
            nmiPendReg <= 1'b1;
         end else if (coNmiReq) begin
            nmiVecReg  <= `FBE_NMI_COR;
            nmiPendReg <= 1'b1;
         end else if (nmiAck | rdNmi) begin
            nmiVecReg  <= `FBE_CAUSE_NONE;
            nmiPendReg <= 1'b0;
         end
      end
   end

   // The cause vector must survive the reset it reports, so only a read
   // or a false-detection reset clears it.
   always @(posedge clock) begin
      if (unResetReq && !falseUncorr)
         resetCauseReg <= `FBE_CAUSE_UNC;
      else if (unResetReq)
         resetCauseReg <= `FBE_CAUSE_NONE;
      else if (rdCause)
         resetCauseReg <= `FBE_CAUSE_NONE;
   end

   fbe_reset_pulse #(
      .WIDTH  (4),
      .CYCLES (`FBE_RST_PULSE_CYC)
   ) u_pulse (
      .clock   (clock),
      .rst     (rst),
      .trigger (unResetReq),
      .pulse   (powerUpClearReset)
   );

   assign nmiRequest = nmiPendReg;
   assign irq        = |(irqStatReg & irqMaskReg);

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      rdNext = 16'h0000;
      case (regAddr)
         `FBE_ADDR_CONFIG:    rdNext = {13'h0000, configReg};
         `FBE_ADDR_FLAG:      rdNext = {14'h0000, corrFlagReg,
                                        uncorrFlagReg};
         `FBE_ADDR_RST_CAUSE: rdNext = resetCauseReg;
         `FBE_ADDR_NMI_VEC:   rdNext = nmiVecReg;
         `FBE_ADDR_IRQ_STAT:  rdNext = {13'h0000, irqStatReg};
         `FBE_ADDR_IRQ_MASK:  rdNext = {13'h0000, irqMaskReg};
         `FBE_ADDR_CLK_STAT:  rdNext = {15'h0000, fastClock};
         default:             rdNext = 16'h0000;
      endcase
   end

   always @(posedge clock) begin
      if (rst)
         regRdData <= 16'h0000;
      else if (regRead)
         regRdData <= rdNext;
      else
         regRdData <= 16'h0000;
   end
endmodule // fbe_bit_error

// ==== testbench/fbe_bit_error_props.sv ====
// Concurrent checks on the bit-error response block ports.
`timescale 1ns/1ps
module fbe_bit_error_props #(
   parameter [31:0] FAST_LIMIT_KHZ = 32'h0000_2EE0
) (
   input wire        clock,
   input wire        rst,
   input wire [3:0]  regAddr,
   input wire [15:0] regWrData,
   input wire        regWrite,
   input wire        memRead,
   input wire        memExec,
   input wire        corrErr,
   input wire        uncorrErr,
   input wire        clkFromInternalOsc,
   input wire [31:0] mainClockKhz,
   input wire        wakeFromLowPower,
   input wire        powerUpClearReset,
   input wire        nmiRequest
);
   reg [2:0] cfg_reg;
   wire fast = clkFromInternalOsc ? (mainClockKhz >= 32'h0000_3E80)
                                  : (mainClockKhz > FAST_LIMIT_KHZ);
   wire ue = memRead && uncorrErr;
   always @(posedge clock)
      if (rst) cfg_reg <= 3'h0;
      else if (regWrite && regAddr == 4'h0) cfg_reg <= regWrData[2:0];
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_wake_cor;
      wakeFromLowPower ##2 (memRead && corrErr && cfg_reg[2]);
   endsequence
   chk_unc_reset: assert property (ue && memExec && cfg_reg[0] |=>
      powerUpClearReset [*2]) else $error("no reset pulse");
   chk_no_reset: assert property (ue && !(memExec && cfg_reg[0]) &&
      !powerUpClearReset |=> !powerUpClearReset) else $error("bad reset");
   chk_unc_nmi: assert property (ue && cfg_reg[1:0] == 2'h3 &&
      !(fast && memExec) |=> nmiRequest) else $error("no unc nmi");
   chk_cor_nmi: assert property (memRead && corrErr && cfg_reg[2]
      |=> nmiRequest) else $error("no cor nmi");
   chk_false_quiet: assert property (ue && memExec && fast &&
      !corrErr && !nmiRequest |=> !nmiRequest) else $error("false nmi");
   chk_rsten_nmi: assert property (ue && !cfg_reg[0] && !corrErr &&
      !nmiRequest |=> !nmiRequest) else $error("nmi w/o reset en");
   chk_wake_acts: assert property (s_wake_cor |=> nmiRequest)
      else $error("wake error ignored");
   chk_pulse_len: assert property ($rose(powerUpClearReset) |=>
      powerUpClearReset ##1 !powerUpClearReset) else $error("pulse len");
endmodule // fbe_bit_error_props
bind fbe_bit_error fbe_bit_error_props #(.FAST_LIMIT_KHZ(FAST_LIMIT_KHZ))
   props_inst (.clock, .rst, .regAddr, .regWrData, .regWrite, .memRead,
   .memExec, .corrErr, .uncorrErr, .clkFromInternalOsc, .mainClockKhz,
   .wakeFromLowPower, .powerUpClearReset, .nmiRequest);

// ==== testbench/fbe_nmi_model.sv ====
// Model of the system NMI logic that takes a pending vector after a delay.
`timescale 1ns/1ps
module fbe_nmi_model #(
   parameter [3:0] DELAY = 4'h6
) (
   input  wire clock,
   input  wire rst,
   input  wire nmiRequest,
   output reg  nmiAck
);
   reg [3:0] cnt_reg = 4'h0;
   initial nmiAck = 1'b0;
   // The slow take lets software read the vector first, as a busy CPU would.
   always @(posedge clock) begin
      nmiAck <= (cnt_reg == DELAY);
      if (rst || !nmiRequest || nmiAck || cnt_reg == DELAY) cnt_reg <= 4'h0;
      else cnt_reg <= cnt_reg + 4'h1;
   end
endmodule // fbe_nmi_model

// ==== testbench/tb_top.sv ====
// Self-checking bench of the bit-error response block.
`timescale 1ns/1ps
module tb_top;
   reg clock = 0, rst = 1, regWrite = 0, regRead = 0, memRead = 0;
   reg memExec = 0, corrErr = 0, uncorrErr = 0, clkFromInternalOsc = 0;
   reg wakeFromLowPower = 0;
   reg [3:0]  regAddr = 4'h0;
   reg [15:0] regWrData = 16'h0000;
   reg [31:0] mainClockKhz = 32'h0000_1F40;
   wire [15:0] regRdData;
   wire nmiAck, powerUpClearReset, nmiRequest, irq;
   integer n_mismatch = 0, n_checks = 0, k;
   always #2 clock = ~clock;
   fbe_bit_error fbe_bit_error_inst (.clock, .rst, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .memRead, .memExec, .corrErr,
      .uncorrErr, .clkFromInternalOsc, .mainClockKhz, .wakeFromLowPower,
      .nmiAck, .powerUpClearReset, .nmiRequest, .irq);
   fbe_nmi_model fbe_nmi_model_inst (.clock, .rst, .nmiRequest, .nmiAck);
   task ck(input [15:0] g, input [15:0] e);
      n_checks = n_checks + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge clock) {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
      @(posedge clock) regWrite <= 1'b0;
   endtask
   task rd(input [3:0] a, input [15:0] e);
      @(posedge clock) {regAddr, regRead} <= {a, 1'b1};
      @(posedge clock) regRead <= 1'b0;
      #1 ck(regRdData, e);
   endtask
   task mem(input x, input c, input u);
      @(posedge clock) {memRead, memExec, corrErr, uncorrErr} <= {1'b1, x, c, u};
      @(posedge clock) memRead <= 1'b0;
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000 n_mismatch = n_mismatch + 1;
      final_report;
   end
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(4'h0, 16'h0000);
      wr(4'h5, 16'h0003);
      wr(4'h0, 16'h0003);
      mem(1, 0, 1);
      #1 ck(powerUpClearReset, 1);
      rd(4'h3, 16'h0010);
      rd(4'h2, 16'h001C);
      rd(4'h1, 16'h0001);
      ck(irq, 1);
      wr(4'h1, 16'h0001);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'h0004);
      mem(0, 1, 0);
      rd(4'h3, 16'h000E);
      rd(4'h1, 16'h0002);
      rd(4'h1, 16'h0002);
      wr(4'h0, 16'h0002);
      mem(1, 0, 1);
      rd(4'h3, 16'h0000);
      rd(4'h1, 16'h0003);
      wr(4'h1, 16'h0003);
      wr(4'h0, 16'h0003);
      mem(1, 0, 1);
      rd(4'h3, 16'h0010);
      @(posedge clock) {clkFromInternalOsc, mainClockKhz} <= 33'h1_0000_3E80;
      rd(4'h6, 16'h0001);
      wr(4'h1, 16'h0001);
      mem(1, 0, 1);
      rd(4'h2, 16'h0000);
      rd(4'h1, 16'h0000);
      @(posedge clock) {clkFromInternalOsc, mainClockKhz} <= 33'h0_0000_2EE1;
      rd(4'h6, 16'h0001);
      @(posedge clock) mainClockKhz <= 32'h0000_2EE0;
      rd(4'h6, 16'h0000);
      wr(4'h4, 16'h0007);
      wr(4'h0, 16'h0004);
      @(posedge clock) wakeFromLowPower <= 1'b1;
      @(posedge clock) wakeFromLowPower <= 1'b0;
      mem(0, 1, 0);
      for (k = 0; k < 20 && nmiRequest; k = k + 1) begin
         @(posedge clock);
         #1;
      end
      ck(nmiRequest, 0);
      rd(4'h4, 16'h0006);
      wr(4'h5, 16'h0000);
      #1 ck(irq, 0);
      wr(4'h5, 16'h0007);
      #1 ck(irq, 1);
      wr(4'h4, 16'h0007);
      #1 ck(irq, 0);
      wr(4'h0, 16'h0000);
      @(posedge clock) wakeFromLowPower <= 1'b1;
      @(posedge clock) wakeFromLowPower <= 1'b0;
      mem(0, 1, 0);
      #1 ck(nmiRequest, 0);
      wr(4'h1, 16'h0003);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'h0004);
      rd(4'h0, 16'h0004);
      final_report;
   end
endmodule // tb_top
